// file: rtl/rrse_exec.v
// executor for return, rotate right through carry and literal minus accumulator
`include "rrse_map.vh"
module rrse_exec #(
  parameter PC_W = 13
) (
  // clock and reset
  input  wire            core_clk,
  input  wire            sys_rst,
  // instruction issue
  input  wire            instr_valid,
  input  wire [13:0]     instr_word,
  // datapath inputs
  input  wire [7:0]      file_rdata,
  input  wire [PC_W-1:0] stack_head,
  input  wire            carry_flag_in,
  input  wire [7:0]      acc_in,
  // instruction flow
  output reg             busy,
  output reg             done,
  // return stack and program counter
  output reg             stack_pop,
  output reg             pc_load,
  output reg [PC_W-1:0]  pc_value,
  // accumulator write
  output reg             acc_we,
  output reg [7:0]       acc_wdata,
  // file register write
  output reg             file_we,
  output reg [6:0]       file_addr,
  output reg [7:0]       file_wdata,
  // status flag writes
  output reg             carry_we,
  output reg             carry_flag,
  output reg             nibble_carry_we,
  output reg             nibble_carry_flag,
  output reg             zero_we,
  output reg             zero_flag
);
  // ----------------------------------------
  // instruction classes and sequencer states
  // ----------------------------------------
  localparam [1:0] CLS_NONE   = 2'h0;
  localparam [1:0] CLS_RETURN = 2'h1;
  localparam [1:0] CLS_ROTATE = 2'h2;
  localparam [1:0] CLS_LMA    = 2'h3;

  localparam [1:0] ST_IDLE    = 2'h0;
  localparam [1:0] ST_FLUSH   = 2'h1;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  // patterns are disjoint; the chain order only settles priority
  function [1:0] op_class;
    input [13:0] word;
    begin
      if (word == `RRSE_OP_RETURN) begin
        op_class = CLS_RETURN;
      end else if (word[`RRSE_OPC_HI_MSB:`RRSE_OPC_HI_LSB] == `RRSE_OP_RRC_HI) begin
        op_class = CLS_ROTATE;
      end else if (word[`RRSE_OPC_HI_MSB:`RRSE_OPC_HI_LSB+1] == `RRSE_OP_LMA_HI) begin
        // low opcode bit is a don't-care
        op_class = CLS_LMA;
      end else begin
        op_class = CLS_NONE;
      end
    end
  endfunction

  reg  [1:0] state_reg;
  reg  [1:0] state_next;
  reg  [1:0] ret_cnt_reg;
  reg  [1:0] ret_cnt_next;

  // a word offered in the flush cycle is dropped, not queued
  wire       issue     = instr_valid && (state_reg == ST_IDLE);
  wire [1:0] cls       = issue ? op_class(instr_word) : CLS_NONE;
  wire       dest_file = instr_word[`RRSE_DEST_BIT];

  // ----------------------------------------
  // datapath
  // ----------------------------------------
  wire [7:0] rot_result;
  wire       rot_carry;
  wire [7:0] sub_result;
  wire       sub_carry;
  wire       sub_nc;
  wire       sub_z;

  rrse_alu u_alu (
    .file_data        (file_rdata),
    .literal          (instr_word[7:0]),
    .acc              (acc_in),
    .carry_in         (carry_flag_in),
    .rot_result       (rot_result),
    .rot_carry        (rot_carry),
    .sub_result       (sub_result),
    .sub_carry        (sub_carry),
    .sub_nibble_carry (sub_nc),
    .sub_zero         (sub_z)
  );

  // ----------------------------------------
  // next values
  // ----------------------------------------
  reg            busy_next;
  reg            done_next;
  reg            stack_pop_next;
  reg            pc_load_next;
  reg [PC_W-1:0] pc_value_next;
  reg            acc_we_next;
  reg [7:0]      acc_wdata_next;
  reg            file_we_next;
  reg [6:0]      file_addr_next;
  reg [7:0]      file_wdata_next;
  reg            carry_we_next;
  reg            carry_flag_next;
  reg            nibble_carry_we_next;
  reg            nibble_carry_flag_next;
  reg            zero_we_next;
  reg            zero_flag_next;

  always @* begin
    // strobes default low, data words hold their last value
    state_next             = state_reg;
    ret_cnt_next           = ret_cnt_reg;
    done_next              = 1'b0;
    stack_pop_next         = 1'b0;
    pc_load_next           = 1'b0;
    pc_value_next          = pc_value;
    acc_we_next            = 1'b0;
    acc_wdata_next         = acc_wdata;
    file_we_next           = 1'b0;
    file_addr_next         = file_addr;
    file_wdata_next        = file_wdata;
    carry_we_next          = 1'b0;
    carry_flag_next        = carry_flag;
    nibble_carry_we_next   = 1'b0;
    nibble_carry_flag_next = nibble_carry_flag;
    zero_we_next           = 1'b0;
    zero_flag_next         = zero_flag;
    case (state_reg)
      ST_IDLE: begin
        if (cls == CLS_RETURN) begin
          // no flag write enables: status stays untouched
          stack_pop_next = 1'b1;
          pc_load_next   = 1'b1;
          pc_value_next  = stack_head;
          state_next     = ST_FLUSH;
          ret_cnt_next   = `RRSE_RETURN_CYCLES - 2'h1;
        end else if (cls == CLS_ROTATE) begin
          done_next       = 1'b1;
          carry_we_next   = 1'b1;
          carry_flag_next = rot_carry;
          if (dest_file) begin
            file_we_next    = 1'b1;
            file_addr_next  = instr_word[`RRSE_ADDR_MSB:0];
            file_wdata_next = rot_result;
          end else begin
            acc_we_next    = 1'b1;
            acc_wdata_next = rot_result;
          end
        end else if (cls == CLS_LMA) begin
          done_next              = 1'b1;
          acc_we_next            = 1'b1;
          acc_wdata_next         = sub_result;
          carry_we_next          = 1'b1;
          carry_flag_next        = sub_carry;
          nibble_carry_we_next   = 1'b1;
          nibble_carry_flag_next = sub_nc;
          zero_we_next           = 1'b1;
          zero_flag_next         = sub_z;
        end
      end
      ST_FLUSH: begin
        // second cycle of return: the fetch slot is flushed and done is raised, nothing is written
        ret_cnt_next = ret_cnt_reg - 2'h1;
        if (ret_cnt_reg == 2'h1) begin
          state_next = ST_IDLE;
          done_next  = 1'b1;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    busy_next = (state_next == ST_FLUSH);
  end

  // ----------------------------------------
  // output and state flip-flops
  // ----------------------------------------
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg         <= ST_IDLE;
      ret_cnt_reg       <= 2'h0;
      busy              <= 1'b0;
      done              <= 1'b0;
      stack_pop         <= 1'b0;
      pc_load           <= 1'b0;
      pc_value          <= `RRSE_PC_RESET;
      acc_we            <= 1'b0;
      acc_wdata         <= `RRSE_W_RESET;
      file_we           <= 1'b0;
      file_addr         <= `RRSE_ADDR_RESET;
      file_wdata        <= `RRSE_FILE_RESET;
      carry_we          <= 1'b0;
      carry_flag        <= 1'b0;
      nibble_carry_we   <= 1'b0;
      nibble_carry_flag <= 1'b0;
      zero_we           <= 1'b0;
      zero_flag         <= 1'b0;
    end else begin
      state_reg         <= state_next;
      ret_cnt_reg       <= ret_cnt_next;
      busy              <= busy_next;
      done              <= done_next;
      stack_pop         <= stack_pop_next;
      pc_load           <= pc_load_next;
      pc_value          <= pc_value_next;
      acc_we            <= acc_we_next;
      acc_wdata         <= acc_wdata_next;
      file_we           <= file_we_next;
      file_addr         <= file_addr_next;
      file_wdata        <= file_wdata_next;
      carry_we          <= carry_we_next;
      carry_flag        <= carry_flag_next;
      nibble_carry_we   <= nibble_carry_we_next;
      nibble_carry_flag <= nibble_carry_flag_next;
      zero_we           <= zero_we_next;
      zero_flag         <= zero_flag_next;
    end
  end
endmodule // rrse_exec

// file: rtl/rrse_map.vh
// opcode patterns, field positions and timing counts for the three-instruction executor
`ifndef RRSE_MAP_VH
`define RRSE_MAP_VH
`define RRSE_OP_RETURN      14'h0008
`define RRSE_OP_RRC_HI      6'h0C
`define RRSE_OP_LMA_HI      5'h1E
`define RRSE_OPC_HI_MSB     13
`define RRSE_OPC_HI_LSB     8
`define RRSE_DEST_BIT       7
`define RRSE_ADDR_MSB       6
`define RRSE_RETURN_CYCLES  2'h2
`define RRSE_PC_RESET       13'h0000
`define RRSE_W_RESET        8'h00
`define RRSE_ADDR_RESET     7'h00
`define RRSE_FILE_RESET     8'h00
`endif

// file: rtl/rrse_alu.v
// combinational datapath: rotate right through carry and literal minus accumulator
`include "rrse_map.vh"
module rrse_alu (
  // operands
  input  wire [7:0] file_data,
  input  wire [7:0] literal,
  input  wire [7:0] acc,
  input  wire       carry_in,
  // rotate result
  output wire [7:0] rot_result,
  output wire       rot_carry,
  // subtract result
  output wire [7:0] sub_result,
  output wire       sub_carry,
  output wire       sub_nibble_carry,
  output wire       sub_zero
);
  wire [8:0] diff;
  wire [4:0] low_diff;

  assign rot_result = {carry_in, file_data[7:1]};
  assign rot_carry  = file_data[0];
  // two's complement: k + ~w + 1, carry out is the inverted borrow
  assign diff       = {1'b0, literal} + {1'b0, ~acc} + 9'h001;
  assign low_diff   = {1'b0, literal[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
  assign sub_result = diff[7:0];
  assign sub_carry  = diff[8];
  assign sub_nibble_carry = low_diff[4];
  assign sub_zero   = (diff[7:0] == 8'h00);
endmodule // rrse_alu

// file: verif/rrse_exec_assertions.sv
// checker for the return, rotate and subtract executor
module rrse_chk #(
  parameter PC_W = 13
) (
  // clock and reset
  input logic            core_clk,
  input logic            sys_rst,
  // instruction issue
  input logic            instr_valid,
  input logic [13:0]     instr_word,
  // datapath inputs
  input logic [7:0]      file_rdata,
  input logic [PC_W-1:0] stack_head,
  input logic            carry_flag_in,
  input logic [7:0]      acc_in,
  // instruction flow
  input logic            busy,
  input logic            done,
  // return stack and program counter
  input logic            stack_pop,
  input logic            pc_load,
  input logic [PC_W-1:0] pc_value,
  // accumulator and file register writes
  input logic            acc_we,
  input logic [7:0]      acc_wdata,
  input logic            file_we,
  input logic [6:0]      file_addr,
  input logic [7:0]      file_wdata,
  // status flag writes
  input logic            carry_we,
  input logic            carry_flag,
  input logic            nibble_carry_we,
  input logic            nibble_carry_flag,
  input logic            zero_we,
  input logic            zero_flag
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire go  = instr_valid & ~busy;
  wire ret = go & (instr_word == 14'h0008);
  wire rot = go & (instr_word[13:8] == 6'h0C);
  wire sub = go & (instr_word[13:9] == 5'h1E);
  a_ret_pop_pc: assert property (
    ret |=> stack_pop && pc_load && pc_value == $past(stack_head))
    else $error("return did not load stack head");
  a_ret_two_cycles: assert property (
    ret |=> busy ##1 (done && !busy))
    else $error("return not done in two cycles");
  a_ret_flags_kept: assert property (
    stack_pop |-> !carry_we && !zero_we && !nibble_carry_we)
    else $error("return touched flags");
  a_busy_refuses: assert property (
    busy |=> !stack_pop && !acc_we && !file_we && !carry_we)
    else $error("word taken during return flush");
  a_rot_carry_out: assert property (
    rot |=> carry_we && done && carry_flag == $past(file_rdata[0]))
    else $error("rotate carry wrong");
  a_rot_carry_only: assert property (
    rot |=> !zero_we && !nibble_carry_we && !stack_pop)
    else $error("rotate touched other flags");
  a_rot_dest_sel: assert property (
    rot |=> file_we == $past(instr_word[7]) && acc_we != file_we)
    else $error("rotate destination wrong");
  a_rot_file_addr: assert property (
    rot && instr_word[7] |=> file_addr == $past(instr_word[6:0]))
    else $error("rotate file address wrong");
  a_rot_value: assert property (
    rot |=> (file_we ? file_wdata : acc_wdata) ==
            {$past(carry_flag_in), $past(file_rdata[7:1])})
    else $error("rotate value wrong");
  a_sub_diff_acc: assert property (
    sub |=> acc_we && !file_we && acc_wdata == $past(instr_word[7:0]) - $past(acc_in))
    else $error("subtract result wrong");
  a_sub_borrow: assert property (
    sub |=> carry_we && carry_flag == ($past(instr_word[7:0]) >= $past(acc_in)))
    else $error("subtract carry wrong");
  a_sub_nibble_zero: assert property (
    sub |=> zero_we && nibble_carry_we && zero_flag == (acc_wdata == 8'h00) &&
            nibble_carry_flag == ($past(instr_word[3:0]) >= $past(acc_in[3:0])))
    else $error("subtract nibble or zero flag wrong");
  c_ret: cover property (ret);
  c_rot: cover property (rot);
  c_rot_file: cover property (rot && instr_word[7]);
  c_sub: cover property (sub);
endmodule // rrse_chk
bind rrse_exec rrse_chk #(.PC_W(PC_W)) u_chk (.*);

// file: verif/rrse_exec_tb.sv
// self-checking bench for the return, rotate and subtract executor
module rrse_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, sys_rst = 1, instr_valid = 0, carry_flag_in = 0;
  logic [13:0] instr_word = 0;
  logic [7:0]  file_rdata = 0, acc_in = 0, acc_wdata, file_wdata;
  logic [12:0] stack_head = 0, pc_value;
  logic        busy, done, stack_pop, pc_load, acc_we, file_we, carry_we, carry_flag;
  logic        nibble_carry_we, nibble_carry_flag, zero_we, zero_flag;
  logic [6:0]  file_addr;
  int          err_count = 0, checks = 0;
  rrse_exec u_dut (.*);
  initial forever #12.5 core_clk = ~core_clk;
  task chk(input string n, input logic [15:0] s, e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task stop_test;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // valid stays up so that issues can run back to back
  task go(input logic [13:0] w, input logic [7:0] f, a, input logic c);
    instr_word = w;
    file_rdata = f;
    acc_in = a;
    carry_flag_in = c;
    instr_valid = 1;
    @(posedge core_clk);
    #2;
  endtask
  task idle;
    instr_valid = 0;
    @(posedge core_clk);
    #2;
  endtask
  task t_return;
    stack_head = 13'h1ABC;
    go(14'h0008, 8'h00, 8'h00, 1'b1);
    chk("pop", {stack_pop, pc_load, busy, carry_we, done}, 5'h1C);
    chk("pc", pc_value, 13'h1ABC);
    go(14'h0C85, 8'hFF, 8'h00, 1'b1);
    chk("done", {done, busy, file_we}, 3'h4);
    idle;
  endtask
  task t_rotate;
    logic [7:0] f;
    for (int i = 0; i < 4; i++) begin
      f = i[0] ? 8'hE6 : 8'h81;
      go({6'h0C, i[1], 7'h25}, f, 8'h00, i[0]);
      chk("dest", {acc_we, file_we}, {~i[1], i[1]});
      chk("rot", i[1] ? file_wdata : acc_wdata, {i[0], f[7:1]});
      chk("cy", {carry_we, carry_flag, done, zero_we}, {1'b1, f[0], 2'h2});
      chk("nw", nibble_carry_we, 1'b0);
      if (i[1]) chk("addr", file_addr, 7'h25);
    end
    idle;
  endtask
  task t_sub;
    logic [15:0] kw [4] = '{16'h0201, 16'h0202, 16'h0203, 16'h1001};
    logic [7:0]  k, w;
    for (int i = 0; i < 4; i++) begin
      {k, w} = kw[i];
      go({5'h1E, i[0], k}, 8'h00, w, 1'b0);
      chk("acc", {acc_we, file_we, acc_wdata}, {2'h2, k - w});
      chk("c", {carry_we, nibble_carry_we, zero_we, carry_flag}, {3'h7, k >= w});
      chk("dz", {nibble_carry_flag, zero_flag}, {k[3:0] >= w[3:0], k == w});
    end
    go(14'h0009, 8'h00, 8'h00, 1'b0);
    chk("none", {stack_pop, acc_we, file_we, done}, 4'h0);
    idle;
  endtask
  // reset in mid-run drops a return in its flush cycle and clears every output
  task t_reset;
    stack_head = 13'h0F0F;
    go(14'h0008, 8'h00, 8'h00, 1'b0);
    chk("pcr", {busy, pc_value}, 14'h2F0F);
    sys_rst = 1;
    instr_valid = 0;
    @(posedge core_clk);
    #2;
    chk("rst", {busy, done, stack_pop, pc_load, acc_we, file_we}, 6'h00);
    chk("rstw", {carry_we, nibble_carry_we, zero_we}, 3'h0);
    chk("rstv", {carry_flag, nibble_carry_flag, zero_flag, file_addr}, 10'h000);
    chk("rstd", {acc_wdata, file_wdata}, 16'h0000);
    chk("rstp", pc_value, 13'h0000);
    sys_rst = 0;
    go({6'h0C, 1'b0, 7'h11}, 8'h02, 8'h00, 1'b1);
    chk("post", {done, acc_we, acc_wdata}, 10'h381);
    idle;
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    #2 sys_rst = 0;
    t_return;
    t_rotate;
    t_sub;
    t_reset;
    stop_test;
  end
  initial begin
    #5us;
    err_count++;
    stop_test;
  end
endmodule // rrse_exec_tb
